// file: hdl/motor_thermal_overload_model.sv
`timescale 1ns/1ps
`include "motor_thermal_consts.svh"
// Summary of operation
// - Cooling type 1 derates cooling at low frequency for motor types 0, 1, 3 and 4, type 2 keeps it flat.
// - A detection level of zero clears the heat and blocks new alarms; a latched alarm holds until cleared.
// - 150 percent of the detection level held for tau raises the alarm.
// - Time constant accepts 0.5 to 75.0 minutes in 0.1 steps, else refused.
// - Cooling type and time constant also drive the early warning.
// - Motor types 1 and 3 break at 33 percent base with 69, 90, 90 percent.
// - Motor types 0 and 4 use rating tables, 5.5-11 kW is 5/6 Hz 90/95/100.
// - Energy saving trims motor voltage to minimise the combined losses.
// - Energy saving acts only at constant speed, else the selected boost.
// - Energy saving is suspended above the base frequency.
module motor_thermal_overload_model #(
  parameter int TICK_CYCLES = `TICK_MS * (`CLK_HZ / 1000)
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic [15:0]               outCurrent,
  input  wire logic [15:0]               outFreq,
  input  wire logic [15:0]               baseFrequencySetting,
  input  wire logic [1:0]                coolingTypeSelect,
  input  wire logic [15:0]               overloadDetectLevel,
  input  wire logic [9:0]                thermalTimeConstant,
  input  wire logic                      timeConstantWrite,
  input  wire logic [2:0]                motorTypeSelect,
  input  wire logic [2:0]                motorRatingClass,
  input  wire logic [2:0]                loadProfileSelect,
  input  wire logic [7:0]                manualBoostLevel,
  input  wire logic                      speedSteady,
  input  wire logic                      alarmClear,
  input  wire logic [6:0]                warnPercent,
  output logic                           overloadAlarm,
  output logic                           overloadWarning,
  output logic                           timeConstantReject,
  output logic [9:0]                     timeConstantHeld,
  output logic                           energySaveActive,
  output motor_thermal_pkg::boost_e      boostMode,
  output logic [7:0]                     boostLevel,
  output logic [7:0]                     voltageTrim
);
  import motor_thermal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] coolAlpha(
    input logic [1:0]  ct,
    input logic [2:0]  mt,
    input logic [2:0]  rc,
    input logic [15:0] f,
    input logic [15:0] fb
  );
    logic [22:0] brk;
    logic [15:0] f2;
    logic [15:0] f3;
    logic [6:0]  a1;
    logic [6:0]  a2;
    logic [6:0]  a3;
    brk = 23'(fb) * 23'(`PCT_BREAK);
    f2  = 16'h0000;
    f3  = 16'h0000;
    a1  = `PCT_FULL;
    a2  = `PCT_FULL;
    a3  = `PCT_FULL;
    if (ct == `COOL_SHAFT) begin
      case (mt)
        3'h1, 3'h3: begin
          f2 = 16'(brk / 23'(`PCT_FULL));
          f3 = f2;
          a1 = `ALPHA_IND_LOW;
          a2 = `ALPHA_IND_HIGH;
          a3 = `ALPHA_IND_HIGH;
        end
        3'h0, 3'h4: begin
          f2 = `F2_STD;
          case (rc)
            3'h0: begin
              f3 = 16'h02bc;
              a1 = 7'h4b;
              a2 = 7'h55;
            end
            3'h1: begin
              f3 = 16'h02bc;
              a1 = 7'h55;
              a2 = 7'h55;
            end
            3'h2: begin
              f3 = 16'h0258;
              a1 = 7'h5a;
              a2 = 7'h5f;
            end
            3'h3: begin
              f3 = 16'h02bc;
              a1 = 7'h55;
              a2 = 7'h55;
            end
            default: begin
              f3 = 16'h01f4;
              a1 = 7'h5c;
            end
          endcase
        end
        default: begin
          f2 = 16'h0000;
        end
      endcase
    end
    if (f < f2) begin
      return a1;
    end else if (f < f3) begin
      return a2;
    end
    return a3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic [1:0] rstSync_q;
  logic       rstSafeN;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstSafeN = rstSync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  thermal_state_s st_q;
  thermal_state_s st_d;

  logic [6:0]  alphaNow;
  logic [22:0] derLevel;
  logic [30:0] ratioNum;
  logic [30:0] ratioWide;
  logic [9:0]  ratioQ8;
  logic [19:0] loadSq;
  logic [15:0] tauTicks;
  logic [39:0] decay;
  logic [39:0] tripThr;
  logic        protOn;
  logic        tick;
  logic        tauOk;
  logic        esEnabled;
  logic        esAllowed;

  assign alphaNow = coolAlpha(coolingTypeSelect, motorTypeSelect,
                              motorRatingClass, outFreq,
                              baseFrequencySetting);
  assign derLevel = 23'(overloadDetectLevel) * 23'(alphaNow);
  assign ratioNum = 31'({outCurrent, 8'h00}) * 31'(`PCT_FULL);
  assign ratioWide = (derLevel == 23'h000000) ? 31'h00000000
                   : ratioNum / 31'(derLevel);
  assign ratioQ8 = (ratioWide > 31'(`RATIO_MAX)) ? `RATIO_MAX
                 : ratioWide[9:0];
  assign loadSq = 20'(ratioQ8) * 20'(ratioQ8);
  // Divide stands in for a reciprocal table; tau changes rarely
  assign tauTicks = 16'(st_q.tau) * `TICKS_PER_TENTH;
  assign decay = st_q.heat / 40'(tauTicks);
  assign tripThr = 40'(tauTicks) * `TRIP_GAIN;
  assign protOn = (overloadDetectLevel != 16'h0000);
  assign tick = (st_q.tickCnt == 22'(TICK_CYCLES - 1));
  assign tauOk = (thermalTimeConstant >= `TAU_MIN) &&
                 (thermalTimeConstant <= `TAU_MAX);
  assign esEnabled = (loadProfileSelect >= 3'h3) &&
                     (loadProfileSelect <= 3'h5);
  assign esAllowed = esEnabled && speedSteady &&
                     (outFreq <= baseFrequencySetting);

  always_comb begin
    st_d = st_q;
    st_d.tickCnt = tick ? 22'h000000 : st_q.tickCnt + 22'h000001;
    st_d.tcReject = timeConstantWrite && !tauOk;
    if (timeConstantWrite && tauOk) begin
      st_d.tau = thermalTimeConstant;
    end
    if (!protOn) begin
      st_d.heat = 40'h0000000000;
    end else if (tick) begin
      st_d.heat = st_q.heat + 40'(loadSq) - decay;
    end
    st_d.alarm = (protOn && (st_q.heat >= tripThr)) ||
                 (st_q.alarm && !alarmClear);
    st_d.warn = protOn &&
                (48'(st_q.heat) * 48'(`PCT_FULL) >=
                 48'(tripThr) * 48'(warnPercent));
    st_d.esActive = esAllowed;
    // Manual boost for profiles 0,1,3,4, whether energy saving runs or not
    st_d.boost = ((loadProfileSelect == 3'h2) ||
                  (loadProfileSelect == 3'h5)) ? BOOST_AUTO
                                                 : BOOST_MANUAL;
    st_d.boostLevel = (st_d.boost == BOOST_MANUAL) ? manualBoostLevel
                                                   : 8'h00;
    if (tick) begin
      if (st_q.esActive) begin
        // Hill climb on current: reverse when losses rose
        if (outCurrent > st_q.prevCur) begin
          st_d.trimDown = !st_q.trimDown;
        end
        if (st_d.trimDown) begin
          st_d.trim = (st_q.trim == 8'h00) ? 8'h00
                    : st_q.trim - 8'h01;
        end else begin
          st_d.trim = (st_q.trim >= `TRIM_MAX) ? `TRIM_MAX
                    : st_q.trim + 8'h01;
        end
        st_d.prevCur = outCurrent;
      end else begin
        // Ramp back slowly so the boost takes over without a step
        st_d.trim = (st_q.trim == 8'h00) ? 8'h00 : st_q.trim - 8'h01;
        st_d.trimDown = 1'b0;
        st_d.prevCur = outCurrent;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSafeN) begin
    if (!rstSafeN) begin
      st_q <= '{heat: 40'h0000000000, tau: `TAU_RESET,
                tickCnt: 22'h000000, alarm: 1'b0, warn: 1'b0,
                tcReject: 1'b0, trim: 8'h00, trimDown: 1'b0,
                prevCur: 16'h0000, esActive: 1'b0,
                boost: BOOST_MANUAL, boostLevel: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign overloadAlarm = st_q.alarm;
  assign overloadWarning = st_q.warn;
  assign timeConstantReject = st_q.tcReject;
  assign timeConstantHeld = st_q.tau;
  assign energySaveActive = st_q.esActive;
  assign boostMode = st_q.boost;
  assign boostLevel = st_q.boostLevel;
  // Trim only moves while energy saving runs, then drains to zero
  assign voltageTrim = st_q.trim;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_hot;
    protOn && (st_q.heat >= tripThr);
  endsequence

  sequence s_badWrite;
    timeConstantWrite && !tauOk;
  endsequence

  property p_flatCooling;
    @(posedge core_clk) disable iff (!rstSafeN)
      (coolingTypeSelect == `COOL_CONSTANT) |-> (alphaNow == `PCT_FULL);
  endproperty
  a_flatCooling: assert property (p_flatCooling)
    else $error("Flat cooling derated");

  property p_disabled;
    @(posedge core_clk) disable iff (!rstSafeN)
      (!protOn && !st_q.alarm) |=> (st_q.heat == 40'h0 && !overloadAlarm);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Alarm raised with protection off");

  property p_trip;
    @(posedge core_clk) disable iff (!rstSafeN)
      s_hot |=> overloadAlarm ##1 (overloadAlarm || $past(alarmClear));
  endproperty
  a_trip: assert property (p_trip)
    else $error("Heat above trip point without alarm");

  property p_tauRange;
    @(posedge core_clk) disable iff (!rstSafeN)
      s_badWrite |=> (timeConstantReject && $stable(timeConstantHeld));
  endproperty
  a_tauRange: assert property (p_tauRange)
    else $error("Out of range time constant accepted");

  property p_warn;
    @(posedge core_clk) disable iff (!rstSafeN)
      (protOn && warnPercent == `PCT_FULL && st_q.heat >= tripThr)
      |=> overloadWarning;
  endproperty
  a_warn: assert property (p_warn)
    else $error("Warning missing at full trip heat");

  property p_indBreak;
    @(posedge core_clk) disable iff (!rstSafeN)
      (coolingTypeSelect == `COOL_SHAFT &&
       (motorTypeSelect == 3'h1 || motorTypeSelect == 3'h3) &&
       32'(outFreq) * 32'(`PCT_FULL) + 32'(`PCT_FULL) <
       32'(baseFrequencySetting) * 32'(`PCT_BREAK))
      |-> (alphaNow == `ALPHA_IND_LOW);
  endproperty
  a_indBreak: assert property (p_indBreak)
    else $error("Low band factor wrong for types 1 and 3");

  property p_midRating;
    @(posedge core_clk) disable iff (!rstSafeN)
      (coolingTypeSelect == `COOL_SHAFT && motorTypeSelect == 3'h0 &&
       motorRatingClass == 3'h2 && outFreq >= `F2_STD &&
       outFreq < 16'h0258) |-> (alphaNow == 7'h5f);
  endproperty
  a_midRating: assert property (p_midRating)
    else $error("Middle factor wrong for 5.5 to 11 kW");

  property p_esGate;
    @(posedge core_clk) disable iff (!rstSafeN)
      (!speedSteady || outFreq > baseFrequencySetting)
      |=> !energySaveActive ##1 (voltageTrim <= $past(voltageTrim));
  endproperty
  a_esGate: assert property (p_esGate)
    else $error("Energy saving active while not allowed");

endmodule

// file: hdl/motor_thermal_consts.svh
`ifndef MOTOR_THERMAL_CONSTS_SVH
`define MOTOR_THERMAL_CONSTS_SVH

// Cooling type codes
`define COOL_SHAFT      2'h1
`define COOL_CONSTANT   2'h2
// Time constant range and reset value, tenths of a minute
`define TAU_MIN         10'h005
`define TAU_MAX         10'h2ee
`define TAU_RESET       10'h032
// Model ticks per tenth of a minute (6 s at 100 ms ticks)
`define TICKS_PER_TENTH 16'h003c
`define TICK_MS         100
`define CLK_HZ          25000000
// Trip threshold per tick of tau, Q16 of (1.5^2)*(1-1/e)
`define TRIP_GAIN       40'h0000016c16
// Percent scaling
`define PCT_FULL        7'h64
`define PCT_BREAK       7'h21
// Cooling factors and breaks for selections 1 and 3
`define ALPHA_IND_LOW   7'h45
`define ALPHA_IND_HIGH  7'h5a
// Break frequency f2 for selections 0 and 4, 0.01 Hz units
`define F2_STD          16'h01f4
// Load ratio ceiling, Q8
`define RATIO_MAX       10'h3ff
// Energy-saving trim ceiling, percent of voltage
`define TRIM_MAX        8'h28

`endif

// file: hdl/motor_thermal_pkg.sv
package motor_thermal_pkg;

  typedef enum logic [0:0] {
    BOOST_MANUAL = 1'b0,
    BOOST_AUTO   = 1'b1
  } boost_e;

  typedef struct packed {
    logic [39:0] heat;
    logic [9:0]  tau;
    logic [21:0] tickCnt;
    logic        alarm;
    logic        warn;
    logic        tcReject;
    logic [7:0]  trim;
    logic        trimDown;
    logic [15:0] prevCur;
    logic        esActive;
    boost_e      boost;
    logic [7:0]  boostLevel;
  } thermal_state_s;

endpackage

// file: sim/motor_sense_model.sv
`timescale 1ns/1ps
// Motor feedback side: measured current and frequency
module motor_sense_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] curTarget,
  input  wire logic [15:0] freqTarget,
  input  wire logic [15:0] rampStep,
  output logic [15:0]      outCurrent,
  output logic [15:0]      outFreq,
  output logic             speedSteady
);
  logic [15:0] nxtFreq;

  initial begin
    outCurrent = 16'h0000;
    outFreq = 16'h0000;
    speedSteady = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp mimics inertia, step 0 jumps at once
  always_comb begin
    nxtFreq = freqTarget;
    if (rampStep != 16'h0000 && outFreq + rampStep < freqTarget) begin
      nxtFreq = outFreq + rampStep;
    end
    if (rampStep != 16'h0000 && outFreq > freqTarget + rampStep) begin
      nxtFreq = outFreq - rampStep;
    end
  end

  // Changes land just after the edge, never on it
  always @(posedge core_clk) begin
    outCurrent <= #1 curTarget;
    outFreq <= #1 nxtFreq;
    speedSteady <= #1 (nxtFreq == freqTarget);
  end
endmodule

// file: sim/motor_thermal_overload_model_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(64'(g), 64'(e))
module motor_thermal_overload_model_bench;
  import motor_thermal_pkg::*;
  localparam int TICK = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] curTarget = 16'h0000, freqTarget = 16'h0000;
  logic [15:0] rampStep = 16'h0000, baseFreq = 16'h1388;
  logic [15:0] level = 16'h0000, outCurrent, outFreq;
  logic [9:0] tau = 10'h000, held, expHeld;
  logic [2:0] motorType = 3'h0, ratingClass = 3'h0, profile = 3'h0;
  logic [1:0] coolType = 2'h2;
  logic [6:0] warnPct = 7'h32;
  logic [7:0] trim, boostLvl, maxTrim;
  logic tauWrite = 1'b0, alarmClear = 1'b0, speedSteady, alarm, warn, rej;
  logic esActive;
  boost_e boostMode;
  int badCount = 0, checksDone = 0, n;

  always #20 core_clk = ~core_clk;

  motor_sense_model sense (.core_clk(core_clk), .curTarget(curTarget),
    .freqTarget(freqTarget), .rampStep(rampStep), .outCurrent(outCurrent),
    .outFreq(outFreq), .speedSteady(speedSteady));

  motor_thermal_overload_model #(.TICK_CYCLES(TICK)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .outCurrent(outCurrent),
    .outFreq(outFreq), .baseFrequencySetting(baseFreq),
    .coolingTypeSelect(coolType), .overloadDetectLevel(level),
    .thermalTimeConstant(tau), .timeConstantWrite(tauWrite),
    .motorTypeSelect(motorType), .motorRatingClass(ratingClass),
    .loadProfileSelect(profile), .manualBoostLevel(8'h12),
    .speedSteady(speedSteady), .alarmClear(alarmClear),
    .warnPercent(warnPct), .overloadAlarm(alarm), .overloadWarning(warn),
    .timeConstantReject(rej), .timeConstantHeld(held),
    .energySaveActive(esActive), .boostMode(boostMode),
    .boostLevel(boostLvl), .voltageTrim(trim));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [63:0] g, input logic [63:0] e);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  task automatic print_verdict();
    if (badCount == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic write_tau(input logic [9:0] v, input logic bad);
    tau = v;
    tauWrite = 1'b1;
    step(1);
    tauWrite = 1'b0;
    if (!bad) expHeld = v;
    `CHK(rej, bad);
    `CHK(held, expHeld);
    step(1);
    `CHK(rej, 1'b0);
  endtask

  // Heat cleared by level 0, then 150 percent load until the alarm
  task automatic trip(input logic [1:0] ct, input logic [2:0] mt,
                      input logic [2:0] rc, input logic [15:0] f,
                      input int lo, input int hi);
    level = 16'h0000;
    alarmClear = 1'b1;
    step(3);
    alarmClear = 1'b0;
    coolType = ct;
    motorType = mt;
    ratingClass = rc;
    freqTarget = f;
    step(3);
    level = 16'h03e8;
    curTarget = 16'h05dc;
    n = 0;
    while (alarm !== 1'b1 && n < hi * TICK) begin
      step(1);
      n++;
    end
    `CHK(alarm, 1'b1);
    `CHK(n >= lo * TICK, 1'b1);
    `CHK(warn, 1'b1);
    curTarget = 16'h0000;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(20);
    `CHK(held, 10'h032);
    `CHK({alarm, warn, rej, esActive, boostMode, boostLvl, trim}, 0);
    rst_n = 1'b1;
    expHeld = 10'h032;
    step(4);
    write_tau(10'h320, 1'b1);
    write_tau(10'h004, 1'b1);
    write_tau(10'h2ef, 1'b1);
    write_tau(10'h2ee, 1'b0);
    write_tau(10'h005, 1'b0);
    // Zero level must never alarm, even at 300 percent
    freqTarget = 16'h0fa0;
    curTarget = 16'h0bb8;
    step(400 * TICK);
    `CHK({alarm, warn}, 2'b00);
    trip(2'h2, 3'h0, 3'h0, 16'h03e8, 270, 330);
    step(10);
    `CHK(alarm, 1'b1);
    trip(2'h1, 3'h1, 3'h0, 16'h01f4, 95, 125);
    trip(2'h1, 3'h3, 3'h0, 16'h0bb8, 190, 240);
    trip(2'h1, 3'h0, 3'h2, 16'h0190, 190, 240);
    trip(2'h1, 3'h4, 3'h2, 16'h0bb8, 270, 330);
    trip(2'h1, 3'h4, 3'h0, 16'h0258, 165, 200);
    // Full-scale warning level lines up with the trip point
    warnPct = 7'h64;
    trip(2'h1, 3'h2, 3'h0, 16'h0190, 270, 330);
    // Energy saving and boost selection per load profile
    freqTarget = 16'h07d0;
    for (int p = 0; p < 6; p++) begin
      profile = 3'(p);
      step(3);
      `CHK(esActive, p >= 3);
      `CHK(boostMode, p == 2 || p == 5);
      `CHK(boostLvl, (p == 2 || p == 5) ? 8'h00 : 8'h12);
    end
    profile = 3'h4;
    maxTrim = 8'h00;
    for (int i = 0; i < 60 * TICK; i++) begin
      step(1);
      if (trim > maxTrim) maxTrim = trim;
    end
    `CHK(maxTrim != 8'h00 && maxTrim <= 8'h28, 1'b1);
    freqTarget = 16'h1389;
    step(3);
    `CHK(esActive, 1'b0);
    freqTarget = 16'h1388;
    step(3);
    `CHK(esActive, 1'b1);
    rampStep = 16'h000a;
    freqTarget = 16'h0bb8;
    step(5);
    `CHK({esActive, boostMode, boostLvl}, {2'b00, 8'h12});
    step(220);
    `CHK(esActive, 1'b1);
    profile = 3'h0;
    step(50 * TICK);
    `CHK(trim, 8'h00);
    print_verdict();
  end

  // Whole run needs about 9000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    badCount++;
    print_verdict();
  end
endmodule
